// [rtl/pm_template_pkg.sv]
// power mode template control: shared constants, types and register map
// assumes an axi4-lite master with 32-bit data; one aligned word per register
package pm_template_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_TEMPLATES = 14;
  localparam int TEMPLATE_WIDTH = 8;
  localparam int ADDR_WIDTH = 8;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ACTIVE_BASE = 8'h00; // 14 words, 0x00..0x34
  localparam logic [7:0] OFS_ALTMODE_BASE = 8'h40; // 14 words, 0x40..0x74
  localparam logic [7:0] OFS_MODE_CTRL = 8'h80;
  localparam logic [7:0] OFS_OSC_CTRL = 8'h84;
  localparam logic [7:0] OFS_LVD_CTRL = 8'h88;
  localparam logic [7:0] OFS_BOOST_CTRL = 8'h8c;
  localparam logic [7:0] OFS_STATUS = 8'h90;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_REQ_LSB = 0; // 2-bit requested mode
  localparam int OSC_XTAL_LP_BIT = 0;
  localparam int OSC_FAST_START_BIT = 1;
  localparam int OSC_SAVE_CLOCKS_BIT = 2;
  localparam int LVD_DIG_EN_BIT = 0;
  localparam int LVD_ANA_EN_BIT = 1;
  localparam int LVD_RST_OPT_BIT = 2;
  localparam int LVD_THRESH_LSB = 4; // 4-bit threshold
  localparam int BOOST_STANDBY_BIT = 0;
  localparam int BOOST_THUMB_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [TEMPLATE_WIDTH-1:0] TEMPLATE_RST = 8'h00;
  localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0002; // fast start on
  localparam logic [31:0] LVD_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BOOST_CTRL_RST = 32'h0000_0002; // refresh on

  // ----------------------------------------------------------------
  // timing and frequency figures
  // ----------------------------------------------------------------
  localparam int SLEEP_OSC_MHZ = 12;
  localparam int FAST_START_MHZ = 48;
  localparam int NORMAL_START_MHZ = 12;
  localparam int CLK_SYS_MHZ = 100;
  localparam int XTAL_HZ = 32768;
  localparam int REFRESH_XTAL_TICKS = 32; // boost refresh period, crystal ticks

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_ALTERNATE,
    MODE_SLEEP,
    MODE_HIBERNATE
  } power_mode_t;

  typedef enum logic [1:0] {
    XTAL_OFF,
    XTAL_NORMAL,
    XTAL_LOW_POWER
  } xtal_power_t;

  typedef struct packed {
    logic [7:0] oscMhz;
    logic digitalClkGate;
  } clk_sel_t;

  typedef struct packed {
    logic standby;
    logic refreshPulse;
  } boost_out_t;

endpackage

// [rtl/xtal_refresh_timer.sv]
// boost refresh pulse generator timed from the crystal tick
// assumes xtalTick is a one-cycle pulse already synchronised to clk_sys
`timescale 1ns/100ps
module xtal_refresh_timer
  import pm_template_pkg::*;
#(
  parameter int TICKS = REFRESH_XTAL_TICKS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic run,
  input wire logic xtalTick,
  output logic pulse
);

  initial begin
    if (TICKS < 1 || TICKS > 65535) begin
      $error("xtal_refresh_timer: TICKS out of range");
    end
  end

  logic [15:0] count_ff;

  // ------------------------------------------------------------
  // count crystal ticks; restart whenever refresh is not wanted
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_ff <= 16'h0000;
      pulse <= 1'b0;
    end else if (clkEn) begin
      pulse <= 1'b0;
      if (!run) begin
        count_ff <= 16'h0000;
      end else if (xtalTick) begin
        if (count_ff == 16'(TICKS - 1)) begin
          count_ff <= 16'h0000;
          pulse <= 1'b1;
        end else begin
          count_ff <= count_ff + 16'h0001;
        end
      end
    end
  end

endmodule

// [rtl/power_mode_template_control.sv]
// power mode template control: per-mode subsystem power and clock gating
// assumes axi4-lite master on clk_sys; pin inputs arrive asynchronously
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module power_mode_template_control
  import pm_template_pkg::*;
#(
  parameter int NUM_REGS = NUM_TEMPLATES,
  parameter int REG_WIDTH = TEMPLATE_WIDTH
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  // axi4-lite slave
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // subsystem interrupts and wake sources (asynchronous pins)
  input wire logic [NUM_REGS*REG_WIDTH-1:0] subsysIrq,
  input wire logic anyIrq,
  input wire logic lowVoltDig,
  input wire logic lowVoltAna,
  input wire logic sleepWake,
  input wire logic xtalTick,
  // gating outputs
  output logic [NUM_REGS*REG_WIDTH-1:0] subsysEnable,
  output power_mode_t powerMode,
  output xtal_power_t xtalPower,
  output clk_sel_t clkSel,
  output logic lvdDigEnable,
  output logic lvdAnaEnable,
  output logic lvdResetOpt,
  output logic [3:0] lvdThreshold,
  output logic lvdWake,
  output boost_out_t boostOut
);

  localparam int NBITS = NUM_REGS * REG_WIDTH;

  initial begin
    if (NUM_REGS < 1 || NUM_REGS > 16 || REG_WIDTH < 1 || REG_WIDTH > 32) begin
      $error("power_mode_template_control: template geometry unsupported");
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers: stage one feeds only stage two
  // ------------------------------------------------------------
  logic [NBITS-1:0] irqMeta_ff, irqSync_ff;
  logic [4:0] pinMeta_ff, pinSync_ff;
  logic anyIrqS, lvdDigS, lvdAnaS, wakeS, xtalLevelS;
  logic xtalPrev_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqMeta_ff <= '0;
      irqSync_ff <= '0;
      pinMeta_ff <= 5'h00;
      pinSync_ff <= 5'h00;
    end else if (clkEn) begin
      irqMeta_ff <= subsysIrq;
      irqSync_ff <= irqMeta_ff;
      pinMeta_ff <= {xtalTick, sleepWake, lowVoltAna, lowVoltDig, anyIrq};
      pinSync_ff <= pinMeta_ff;
    end
  end

  assign anyIrqS = pinSync_ff[0];
  assign lvdDigS = pinSync_ff[1];
  assign lvdAnaS = pinSync_ff[2];
  assign wakeS = pinSync_ff[3];
  assign xtalLevelS = pinSync_ff[4];

  // crystal edge detect on the synchronised level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xtalPrev_ff <= 1'b0;
    end else if (clkEn) begin
      xtalPrev_ff <= xtalLevelS;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write path: address and data taken in either order
  // ------------------------------------------------------------
  logic awHeld_ff, wHeld_ff;
  logic [ADDR_WIDTH-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  logic [ADDR_WIDTH-1:0] wrAddr;

  assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  assign wrAddr = awAddr_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clkEn) begin
      s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addrMapped(wrAddr) ? 2'h0 : 2'h2; // slverr when unmapped
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------
  function automatic logic addrMapped(input logic [ADDR_WIDTH-1:0] a);
    logic hit;
    hit = (a[1:0] == 2'h0) && ((a < 8'(OFS_ACTIVE_BASE + 4 * NUM_REGS))
      || (a >= OFS_ALTMODE_BASE && a < 8'(OFS_ALTMODE_BASE + 4 * NUM_REGS))
      || (a >= OFS_MODE_CTRL && a <= OFS_STATUS));
    return hit;
  endfunction

  // byte-lane merge for narrow control words
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // template banks: writes act at once, reset clears them
  // ------------------------------------------------------------
  logic [NBITS-1:0] actBank_ff, altBank_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_tmpl
      logic [7:0] actOfs, altOfs;
      logic [REG_WIDTH-1:0] irqBits;
      assign actOfs = 8'(OFS_ACTIVE_BASE + 4 * gi);
      assign altOfs = 8'(OFS_ALTMODE_BASE + 4 * gi);
      assign irqBits = irqSync_ff[gi*REG_WIDTH +: REG_WIDTH];
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          actBank_ff[gi*REG_WIDTH +: REG_WIDTH] <= TEMPLATE_RST;
          altBank_ff[gi*REG_WIDTH +: REG_WIDTH] <= TEMPLATE_RST;
        end else if (clkEn) begin
          // interrupt set is ORed after the write so it wins a collision
          if (doWrite && wrAddr == actOfs) begin
            actBank_ff[gi*REG_WIDTH +: REG_WIDTH] <=
              wData_ff[REG_WIDTH-1:0] | irqBits;
          end else begin
            actBank_ff[gi*REG_WIDTH +: REG_WIDTH] <=
              actBank_ff[gi*REG_WIDTH +: REG_WIDTH] | irqBits;
          end
          if (doWrite && wrAddr == altOfs) begin
            altBank_ff[gi*REG_WIDTH +: REG_WIDTH] <=
              wData_ff[REG_WIDTH-1:0] | irqBits;
          end else begin
            altBank_ff[gi*REG_WIDTH +: REG_WIDTH] <=
              altBank_ff[gi*REG_WIDTH +: REG_WIDTH] | irqBits;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [31:0] oscCtrl_ff, lvdCtrl_ff, boostCtrl_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      oscCtrl_ff <= OSC_CTRL_RST;
      lvdCtrl_ff <= LVD_CTRL_RST;
      boostCtrl_ff <= BOOST_CTRL_RST;
    end else if (clkEn && doWrite) begin
      if (wrAddr == OFS_OSC_CTRL) begin
        oscCtrl_ff <= merge(oscCtrl_ff, wData_ff, wStrb_ff) & 32'h0000_0007;
      end
      if (wrAddr == OFS_LVD_CTRL) begin
        lvdCtrl_ff <= merge(lvdCtrl_ff, wData_ff, wStrb_ff) & 32'h0000_00f7;
      end
      if (wrAddr == OFS_BOOST_CTRL) begin
        boostCtrl_ff <= merge(boostCtrl_ff, wData_ff, wStrb_ff) & 32'h0000_0003;
      end
    end
  end

  // ------------------------------------------------------------
  // power mode machine
  // ------------------------------------------------------------
  power_mode_t nxt_mode;
  logic modeWrite;
  power_mode_t reqMode;
  logic lvdWakeNow;

  assign modeWrite = doWrite && wrAddr == OFS_MODE_CTRL && wStrb_ff[0];
  assign reqMode = power_mode_t'(wData_ff[MODE_REQ_LSB +: 2]);
  // enabled detector, digital or analog, is a sleep wake source
  assign lvdWakeNow = (lvdCtrl_ff[LVD_DIG_EN_BIT] && lvdDigS)
    || (lvdCtrl_ff[LVD_ANA_EN_BIT] && lvdAnaS);

  always_comb begin
    nxt_mode = powerMode;
    case (powerMode)
      MODE_ACTIVE: begin
        if (modeWrite) begin
          nxt_mode = reqMode;
        end
      end
      MODE_ALTERNATE: begin
        if (anyIrqS) begin
          nxt_mode = MODE_ACTIVE;
        end else if (modeWrite) begin
          nxt_mode = reqMode;
        end
      end
      MODE_SLEEP: begin
        if (wakeS || anyIrqS || lvdWakeNow) begin
          nxt_mode = MODE_ACTIVE;
        end
      end
      MODE_HIBERNATE: begin
        if (wakeS) begin
          nxt_mode = MODE_ACTIVE;
        end
      end
      default: nxt_mode = MODE_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      powerMode <= MODE_ACTIVE;
    end else if (clkEn) begin
      powerMode <= nxt_mode;
    end
  end

  // ------------------------------------------------------------
  // gating outputs, registered from next mode and the current bank registers so a
  // mode change swaps every enable together
  // ------------------------------------------------------------
  logic [NBITS-1:0] nxt_enable;

  always_comb begin
    case (nxt_mode)
      MODE_ACTIVE: nxt_enable = actBank_ff;
      MODE_ALTERNATE: nxt_enable = altBank_ff;
      default: nxt_enable = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      subsysEnable <= '0;
    end else if (clkEn) begin
      subsysEnable <= nxt_enable;
    end
  end

  // boost pins share one struct; each half keeps a single driver
  logic boostStandby_ff;
  logic refreshPulse;
  assign boostOut = '{standby: boostStandby_ff, refreshPulse: refreshPulse};

  // crystal power and clock choice follow the mode; boost standby follows its control bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xtalPower <= XTAL_NORMAL;
      clkSel <= '{oscMhz: 8'(FAST_START_MHZ), digitalClkGate: 1'b0};
      boostStandby_ff <= 1'b0;
    end else if (clkEn) begin
      case (nxt_mode)
        MODE_SLEEP: begin
          xtalPower <= oscCtrl_ff[OSC_XTAL_LP_BIT] ? XTAL_LOW_POWER : XTAL_NORMAL;
          clkSel <= '{oscMhz: 8'(SLEEP_OSC_MHZ),
                      digitalClkGate: oscCtrl_ff[OSC_SAVE_CLOCKS_BIT]};
        end
        MODE_HIBERNATE: begin
          xtalPower <= XTAL_OFF;
          clkSel <= '{oscMhz: 8'(SLEEP_OSC_MHZ), digitalClkGate: 1'b1};
        end
        default: begin
          xtalPower <= XTAL_NORMAL;
          clkSel <= '{oscMhz: oscCtrl_ff[OSC_FAST_START_BIT] ? 8'(FAST_START_MHZ)
                              : 8'(NORMAL_START_MHZ), digitalClkGate: 1'b0};
        end
      endcase
      boostStandby_ff <= boostCtrl_ff[BOOST_STANDBY_BIT];
    end
  end

  // detector enables and wake flag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lvdDigEnable <= 1'b0;
      lvdAnaEnable <= 1'b0;
      lvdResetOpt <= 1'b0;
      lvdThreshold <= 4'h0;
      lvdWake <= 1'b0;
    end else if (clkEn) begin
      lvdDigEnable <= lvdCtrl_ff[LVD_DIG_EN_BIT];
      lvdAnaEnable <= lvdCtrl_ff[LVD_ANA_EN_BIT];
      lvdResetOpt <= lvdCtrl_ff[LVD_RST_OPT_BIT];
      lvdThreshold <= lvdCtrl_ff[LVD_THRESH_LSB +: 4];
      lvdWake <= (powerMode == MODE_SLEEP) && lvdWakeNow;
    end
  end

  // boost refresh only while asleep with standby and refresh enabled
  xtal_refresh_timer u_refresh (
    .clk_sys(clk_sys),
    .srst(srst),
    .clkEn(clkEn),
    .run((powerMode == MODE_SLEEP) && boostCtrl_ff[BOOST_STANDBY_BIT]
         && boostCtrl_ff[BOOST_THUMB_BIT]),
    .xtalTick(xtalLevelS && !xtalPrev_ff),
    .pulse(refreshPulse)
  );

  // ------------------------------------------------------------
  // axi4-lite read path, one cycle after address acceptance
  // ------------------------------------------------------------
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (s_axi_araddr == 8'(OFS_ACTIVE_BASE + 4 * i)) begin
        rdMux = 32'(actBank_ff[i*REG_WIDTH +: REG_WIDTH]);
      end
      if (s_axi_araddr == 8'(OFS_ALTMODE_BASE + 4 * i)) begin
        rdMux = 32'(altBank_ff[i*REG_WIDTH +: REG_WIDTH]);
      end
    end
    case (s_axi_araddr)
      OFS_MODE_CTRL: rdMux = {30'h0, powerMode};
      OFS_OSC_CTRL: rdMux = oscCtrl_ff;
      OFS_LVD_CTRL: rdMux = lvdCtrl_ff;
      OFS_BOOST_CTRL: rdMux = boostCtrl_ff;
      OFS_STATUS: rdMux = {26'h0, lvdAnaS, lvdDigS, xtalPower, powerMode};
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= addrMapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [testbench/pm_template_sva.sv]
// checker: mode, gating and reset relations at the block ports
// assumes bind onto the top module; one clock, synchronous reset
`timescale 1ns/100ps
module pm_template_sva
  import pm_template_pkg::*;
#(
  parameter int NUM_REGS = NUM_TEMPLATES,
  parameter int REG_WIDTH = TEMPLATE_WIDTH
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic anyIrq,
  input wire logic [NUM_REGS*REG_WIDTH-1:0] subsysIrq,
  input wire logic [NUM_REGS*REG_WIDTH-1:0] subsysEnable,
  input power_mode_t powerMode,
  input xtal_power_t xtalPower,
  input clk_sel_t clkSel,
  input wire logic lvdDigEnable,
  input wire logic lvdAnaEnable,
  input wire logic lvdWake,
  input boost_out_t boostOut
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // reset values, checked on the first edge after release
  AST_RST_MODE: assert property (
    $past(srst) |-> subsysEnable == '0 && powerMode == MODE_ACTIVE)
    else $error("state not cleared by reset");
  AST_RST_OSC: assert property (
    $past(srst) |-> xtalPower == XTAL_NORMAL && clkSel.oscMhz == 8'(FAST_START_MHZ))
    else $error("oscillator reset setting wrong");
  AST_RST_LVD: assert property (
    $past(srst) |-> !lvdDigEnable && !lvdAnaEnable)
    else $error("detector enabled after reset");
  // one cycle of slack; the output registers from the same next mode as powerMode
  AST_XTAL_AWAKE: assert property (
    (powerMode == MODE_ACTIVE || powerMode == MODE_ALTERNATE)[*2] |-> xtalPower == XTAL_NORMAL)
    else $error("crystal not normal while awake");
  AST_XTAL_HIB: assert property (
    (powerMode == MODE_HIBERNATE)[*2] |-> xtalPower == XTAL_OFF)
    else $error("crystal running in hibernate");
  AST_SLEEP_CLK: assert property (
    (powerMode == MODE_SLEEP)[*2] |-> clkSel.oscMhz == 8'(SLEEP_OSC_MHZ))
    else $error("sleep clock not 12 MHz");
  AST_BANK_OFF: assert property (
    powerMode == MODE_SLEEP || powerMode == MODE_HIBERNATE |-> subsysEnable == '0)
    else $error("subsystems enabled while asleep");
  AST_ALT_WAKE: assert property (
    (powerMode == MODE_ALTERNATE && anyIrq)[*3] |-> ##[0:4] powerMode == MODE_ACTIVE)
    else $error("interrupt did not end alternate mode");
  AST_IRQ_SET: assert property (
    (subsysIrq[3] && powerMode == MODE_ACTIVE)[*6] |-> subsysEnable[3])
    else $error("interrupt did not set enable");
  AST_LVD_WAKE: assert property (
    lvdWake |-> powerMode == MODE_SLEEP || $past(powerMode) == MODE_SLEEP)
    else $error("detector wake outside sleep");
  AST_REFRESH: assert property (
    boostOut.refreshPulse |=> !boostOut.refreshPulse)
    else $error("refresh pulse too long");

  COV_SLEEP_WAKE: cover property (powerMode == MODE_SLEEP ##1 powerMode == MODE_ACTIVE);
  COV_ALT_WAKE: cover property (powerMode == MODE_ALTERNATE ##1 powerMode == MODE_ACTIVE);
  COV_REFRESH: cover property (boostOut.refreshPulse);
endmodule

bind power_mode_template_control pm_template_sva #(
  .NUM_REGS(NUM_REGS), .REG_WIDTH(REG_WIDTH)) u_sva (
  .clk_sys(clk_sys), .srst(srst), .anyIrq(anyIrq), .subsysIrq(subsysIrq),
  .subsysEnable(subsysEnable), .powerMode(powerMode), .xtalPower(xtalPower),
  .clkSel(clkSel), .lvdDigEnable(lvdDigEnable), .lvdAnaEnable(lvdAnaEnable),
  .lvdWake(lvdWake), .boostOut(boostOut));

// [testbench/testbench.sv]
// self-checking bench for power mode template control
// assumes the package register map and an axi4-lite slave on the top
`timescale 1ns/100ps
module testbench
  import pm_template_pkg::*;
();
  localparam int W = NUM_TEMPLATES * TEMPLATE_WIDTH;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h0, rData, rdTmp;
  logic awReady, wReady, bValid, arReady, rValid, lvdDig, lvdAna, lvdRst, lvdWk;
  logic [1:0] bResp, rResp;
  logic [W-1:0] irq = '0, en;
  logic anyIrq = 1'b0, lvDig = 1'b0, lvAna = 1'b0, wake = 1'b0, tick = 1'b0, tickOn = 1'b0;
  logic [3:0] tickCnt = 4'h0, lvdThr;
  power_mode_t mode;
  xtal_power_t xtal;
  clk_sel_t csel;
  boost_out_t boost;
  int fails = 0, comparisons = 0, pulses = 0, wakes = 0;

  power_mode_template_control DUT (
    .clk_sys(clk_sys), .srst(srst), .clkEn(1'b1),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .subsysIrq(irq), .anyIrq(anyIrq), .lowVoltDig(lvDig), .lowVoltAna(lvAna),
    .sleepWake(wake), .xtalTick(tick), .subsysEnable(en), .powerMode(mode),
    .xtalPower(xtal), .clkSel(csel), .lvdDigEnable(lvdDig), .lvdAnaEnable(lvdAna),
    .lvdResetOpt(lvdRst), .lvdThreshold(lvdThr), .lvdWake(lvdWk), .boostOut(boost));

  always #5 clk_sys = ~clk_sys;
  // crystal stand-in: 16-cycle period, still unless a test asks
  always @(posedge clk_sys) begin
    tickCnt <= tickCnt + 4'h1;
    tick <= tickOn & tickCnt[3];
    if (boost.refreshPulse === 1'b1) pulses <= pulses + 1;
    if (lvdWk === 1'b1) wakes <= wakes + 1;
  end

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // outputs are sampled 1 ns after the edge so their updates have landed
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    fork
      begin
        do @(posedge clk_sys); while (awReady !== 1'b1);
        awValid <= 1'b0;
      end
      begin
        do @(posedge clk_sys); while (wReady !== 1'b1);
        wValid <= 1'b0;
      end
    join
    do @(posedge clk_sys); while (bValid !== 1'b1);
    bReady <= 1'b0;
    check(bResp, er);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge clk_sys); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clk_sys); while (rValid !== 1'b1);
    rReady <= 1'b0;
    d = rData;
    check(rResp, er);
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, 2'b00);
    check(d, exp);
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic waitMode(input power_mode_t m);
    for (int k = 0; k < 300 && mode !== m; k++) @(posedge clk_sys) #1;
    check(mode, m);
  endtask
  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    clks(1);
    check(xtal, XTAL_NORMAL);
    check(csel.oscMhz, FAST_START_MHZ);
    rdc(OFS_OSC_CTRL, OSC_CTRL_RST);
    rdc(OFS_LVD_CTRL, LVD_CTRL_RST);
    rdc(OFS_BOOST_CTRL, BOOST_CTRL_RST);
    rdc(OFS_STATUS, 32'h4);
    $display("test reset done");
    // boot load of both banks; alternate writes must not touch gating
    for (int i = 0; i < NUM_TEMPLATES; i++) begin
      wr(OFS_ACTIVE_BASE + 8'(4 * i), 32'h10 + i);
      check(en[i*8 +: 8], 32'h10 + i);
      wr(OFS_ALTMODE_BASE + 8'(4 * i), 32'ha0 + i);
      check(en[i*8 +: 8], 32'h10 + i);
    end
    wr(OFS_MODE_CTRL, 32'h1);
    waitMode(MODE_ALTERNATE);
    for (int i = 0; i < NUM_TEMPLATES; i++) check(en[i*8 +: 8], 32'ha0 + i);
    @(posedge clk_sys) anyIrq <= 1'b1;
    waitMode(MODE_ACTIVE);
    check(en[7:0], 32'h10);
    @(posedge clk_sys) anyIrq <= 1'b0;
    $display("test banks done");
    @(posedge clk_sys) irq[3] <= 1'b1;
    clks(6);
    check(en[3], 1'b1);
    rdc(OFS_ACTIVE_BASE, 32'h18);
    rdc(OFS_ALTMODE_BASE, 32'ha8);
    @(posedge clk_sys) irq[3] <= 1'b0;
    $display("test irq done");
    wr(OFS_OSC_CTRL, 32'h5);
    wr(OFS_LVD_CTRL, 32'h53);
    check({lvdRst, lvdAna, lvdDig, lvdThr}, 32'h35);
    @(posedge clk_sys) lvAna <= 1'b1;
    rdc(OFS_STATUS, 32'h24);
    @(posedge clk_sys) lvAna <= 1'b0;
    wr(OFS_BOOST_CTRL, 32'h3);
    check(boost.standby, 1'b1);
    wr(OFS_MODE_CTRL, 32'h2);
    waitMode(MODE_SLEEP);
    tickOn = 1'b1;
    clks(3);
    check(xtal, XTAL_LOW_POWER);
    check(csel, {8'h0c, 1'b1});
    check({31'h0, |en}, 32'h0);
    clks(1100);
    check(pulses > 0, 1'b1);
    @(posedge clk_sys) lvDig <= 1'b1;
    waitMode(MODE_ACTIVE);
    clks(2);
    check(xtal, XTAL_NORMAL);
    check(wakes, 1);
    check(csel, {8'(NORMAL_START_MHZ), 1'b0});
    @(posedge clk_sys) lvDig <= 1'b0;
    tickOn = 1'b0;
    wr(OFS_BOOST_CTRL, 32'h2);
    check(boost.standby, 1'b0);
    wr(OFS_MODE_CTRL, 32'h3);
    waitMode(MODE_HIBERNATE);
    clks(2);
    check(xtal, XTAL_OFF);
    @(posedge clk_sys) wake <= 1'b1;
    waitMode(MODE_ACTIVE);
    @(posedge clk_sys) wake <= 1'b0;
    $display("test sleep done");
    wr(8'hfc, 32'h1, 2'b10);
    rd(8'hfc, rdTmp, 2'b10);
    check(rdTmp, 32'h0);
    @(posedge clk_sys) srst <= 1'b1;
    clks(2);
    @(posedge clk_sys) srst <= 1'b0;
    rdc(OFS_ACTIVE_BASE, 32'h0);
    check({31'h0, |en}, 32'h0);
    $display("test reset again done");
    summarize();
  end

  // run needs about 1400 cycles; cut a hang at 20000
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule
